// file: hdl/cmpp_control_page.sv
// Control mode page registers and the command policy they steer
`include "cmpp_params.svh"
`default_nettype none
module cmpp_control_page #(
  parameter int          NI               = 8,
  parameter int          IW               = 3,
  parameter logic [15:0] SELFTEST_SECONDS = 16'h1C20
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [7:0]    paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Command check request
  input  wire logic          cmd_valid,
  input  wire logic          cmd_is_write,
  input  wire logic          cmd_has_pi,
  input  wire logic [2:0]    cmd_protect_field,
  input  wire logic          medium_pi_formatted,
  input  wire logic          inquiry_check_flag,
  // Command check answer
  output logic               rsp_valid,
  output logic               rsp_check_pi,
  output logic               rsp_reject,
  output logic               rsp_sense_descriptor,
  output logic [3:0]         rsp_sense_key,
  output logic [7:0]         rsp_sense_code,
  output logic               rsp_tag_preserve,
  output logic               rsp_tag_from_page,
  // Error events and queue actions
  input  wire logic          err_valid,
  input  wire logic [IW-1:0] err_initiator,
  input  wire logic          ca_clear,
  input  wire logic [NI-1:0] queued_mask,
  output logic               block_tasks,
  output logic               abort_all,
  output logic               abort_initiator_valid,
  output logic [IW-1:0]      abort_initiator_id,
  // Unit attention
  input  wire logic          ua_ack_valid,
  input  wire logic [IW-1:0] ua_ack_id,
  input  wire logic [IW-1:0] ua_query_id,
  output logic               ua_pending,
  output logic [7:0]         ua_sense_code,
  // Policy levels
  output logic               reorder_restricted,
  output logic               reorder_free,
  output logic               reorder_disabled,
  output logic               vpd_blocklen_enable,
  output logic [2:0]         ptype_report,
  output logic [15:0]        selftest_seconds
);
  import cmpp_pkg::*;
  // Reset and header words held as typed constants so fields can be selected
  localparam logic [7:0] SENSE_RST = `CMPP_SENSE_RST;
  localparam logic [7:0] QUEUE_RST = `CMPP_QUEUE_RST;
  localparam logic [7:0] PAGE_CODE = `CMPP_PAGE_CODE;

  // ============================================================
  // State
  typedef struct packed {
    cmpp_pkg::cmpp_state_t st;       // Error handling state
    logic          pready;           // APB answer pending
    logic          pslverr;          // APB error for this transfer
    logic [31:0]   prdata;           // APB read data
    logic          zcd;              // Zero-protect-check disable
    logic          dsense;           // Descriptor sense select
    logic [3:0]    qam;              // Reordering rule
    logic [1:0]    qem;              // Queue error field
    logic          own;              // Tag ownership
    logic          tpe;              // Tag page enable
    logic          rjw;              // Reject unprotected write
    logic          blr;              // Block length report
    logic [15:0]   busy;             // Busy wait limit, stored only
    logic          rsp_valid;        // Answer strobe
    logic          rsp_check_pi;     // Check protection info
    logic          rsp_reject;       // End with check condition
    logic          rsp_desc;         // Descriptor sense format
    logic [3:0]    rsp_key;          // Sense key
    logic [7:0]    rsp_code;         // Additional sense code
    logic          rsp_tag_preserve; // Leave application tag alone
    logic          rsp_tag_page;     // Expected tag from tag page
    logic          block;            // Tasks held
    logic          abort_all;        // Abort everything pulse
    logic          abort_one;        // Abort one initiator pulse
    logic [IW-1:0] abort_id;         // Initiator to abort
    logic          r_restr;          // Restricted reordering
    logic          r_free;           // Unrestricted reordering
    logic          r_off;            // Reordering disabled
    logic          vpd_en;           // Serve block length page
    logic [2:0]    ptype;            // Reported protection type
    logic [15:0]   selft;            // Self-test seconds
    logic [NI-1:0] ua_set;           // Attention set vector to table
    logic          ua_cause;         // Cause of that set
  } cmpp_top_s_t;

  cmpp_top_s_t   s;
  cmpp_top_s_t   next_s;
  logic          acc;        // Access phase
  logic          commit;     // Transfer completes this edge
  logic [5:0]    idx;        // Register index
  logic [31:0]   rd_word;    // Decoded read data
  logic          rd_err;     // Decoded error
  logic [NI-1:0] err_onehot; // Erring initiator as a bit
  logic          chk;        // Protection check decision
  logic          rej;        // Unprotected write rejection
  logic          blr_new;    // Written report bit

  assign acc        = psel && penable;
  assign commit     = acc && s.pready;
  assign idx        = paddr[7:2];
  assign err_onehot = {{(NI-1){1'b0}}, 1'b1} << err_initiator;
  assign blr_new    = pwdata[`CMPP_BIT_BLR];
  // A zero protect field skips the check only when disabled
  assign chk        = cmd_has_pi && !(s.zcd && (cmd_protect_field == 3'h0));
  assign rej        = cmd_is_write && !cmd_has_pi && s.rjw && medium_pi_formatted;

  // ============================================================
  // Read decode and write checks; unsupported fields read zero
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    case (idx)
      `CMPP_IDX_CODE: begin
        rd_word = {24'h00_0000, `CMPP_PAGE_CODE};
        rd_err  = pwrite && (pwdata[5:0] != PAGE_CODE[5:0]);
      end
      `CMPP_IDX_LEN: begin
        rd_word = {24'h00_0000, `CMPP_PAGE_LEN};
        rd_err  = pwrite && (pwdata[7:0] != `CMPP_PAGE_LEN);
      end
      `CMPP_IDX_SENSE: begin
        rd_word[`CMPP_BIT_ZCD]    = s.zcd;
        rd_word[`CMPP_BIT_DSENSE] = s.dsense;
      end
      `CMPP_IDX_QUEUE: begin
        rd_word[`CMPP_QAM_HI:`CMPP_QAM_LO]   = s.qam;
        rd_word[`CMPP_QEM_HI:`CMPP_QEM_LO]   = s.qem;
        // Reserved reordering and queue error codes are refused
        rd_err = pwrite &&
                 (((pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] != `CMPP_QAM_RESTRICT) &&
                   (pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] != `CMPP_QAM_FREE) &&
                   (pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] != `CMPP_QAM_OFF)) ||
                  (pwdata[`CMPP_QEM_HI:`CMPP_QEM_LO] == `CMPP_QEM_RSVD));
      end
      `CMPP_IDX_FIXED: begin
        rd_word = 32'h0000_0000;
      end
      `CMPP_IDX_PROT: begin
        rd_word[`CMPP_BIT_OWN] = s.own;
        rd_word[`CMPP_BIT_TPE] = s.tpe;
        rd_word[`CMPP_BIT_RJW] = s.rjw;
        rd_word[`CMPP_BIT_BLR] = s.blr;
      end
      `CMPP_IDX_UNUSED: begin
        rd_word = 32'h0000_0000;
      end
      `CMPP_IDX_BUSY: begin
        rd_word[15:0] = s.busy;
      end
      `CMPP_IDX_SELFT: begin
        rd_word[15:0] = s.selft;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // ============================================================
  // Next state
  always_comb begin
    next_s           = s;
    next_s.rsp_valid = 1'b0;
    next_s.abort_all = 1'b0;
    next_s.abort_one = 1'b0;
    next_s.ua_set    = '0;
    next_s.ua_cause  = 1'b0;

    // APB: answer in the second access cycle, write lands at completion
    if (acc && !s.pready) begin
      next_s.pready  = 1'b1;
      next_s.prdata  = pwrite ? 32'h0000_0000 : rd_word;
      next_s.pslverr = rd_err;
    end else if (commit) begin
      next_s.pready  = 1'b0;
      next_s.pslverr = 1'b0;
      next_s.prdata  = 32'h0000_0000;
      if (pwrite && !s.pslverr) begin
        case (idx)
          `CMPP_IDX_SENSE: begin
            next_s.zcd    = pwdata[`CMPP_BIT_ZCD];
            next_s.dsense = pwdata[`CMPP_BIT_DSENSE];
          end
          `CMPP_IDX_QUEUE: begin
            next_s.qam     = pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO];
            next_s.qem     = pwdata[`CMPP_QEM_HI:`CMPP_QEM_LO];
            next_s.r_restr = pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] == `CMPP_QAM_RESTRICT;
            next_s.r_free  = pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] == `CMPP_QAM_FREE;
            next_s.r_off   = pwdata[`CMPP_QAM_HI:`CMPP_QAM_LO] == `CMPP_QAM_OFF;
          end
          `CMPP_IDX_PROT: begin
            next_s.own    = pwdata[`CMPP_BIT_OWN];
            next_s.tpe    = pwdata[`CMPP_BIT_TPE];
            next_s.rjw    = pwdata[`CMPP_BIT_RJW];
            next_s.blr    = blr_new;
            next_s.vpd_en = blr_new;
            next_s.ptype  = blr_new ? `CMPP_PTYPE_BLKLEN : `CMPP_PTYPE_NONE;
            // A changed report bit raises attention for every initiator
            if (blr_new != s.blr) begin
              next_s.ua_set = '1;
            end
          end
          `CMPP_IDX_BUSY: begin
            next_s.busy = pwdata[15:0];
          end
          default: begin
            next_s.busy = s.busy;
          end
        endcase
      end
    end

    // Command check: one answer per request, next cycle
    if (cmd_valid) begin
      next_s.rsp_valid        = 1'b1;
      next_s.rsp_check_pi     = chk;
      next_s.rsp_reject       = rej;
      next_s.rsp_desc         = s.dsense;
      next_s.rsp_key          = rej ? `CMPP_KEY_ILLEGAL : `CMPP_KEY_NONE;
      next_s.rsp_code         = rej ? `CMPP_ASC_BAD_CDB : `CMPP_ASC_NONE;
      next_s.rsp_tag_preserve = s.own;
      next_s.rsp_tag_page     = s.tpe && s.own && chk && inquiry_check_flag;
    end

    // Error handling by queue error field
    unique case (s.st)
      CMPP_RUN: begin
        if (err_valid) begin
          case (s.qem)
            `CMPP_QEM_BLOCK: begin
              next_s.st    = CMPP_CA;
              next_s.block = 1'b1;
            end
            `CMPP_QEM_ALL: begin
              next_s.abort_all = 1'b1;
              next_s.ua_set    = next_s.ua_set | (queued_mask & ~err_onehot);
              next_s.ua_cause  = 1'b1;
            end
            `CMPP_QEM_OWN: begin
              next_s.abort_one = 1'b1;
              next_s.abort_id  = err_initiator;
            end
            default: begin
              next_s.abort_one = 1'b0;
            end
          endcase
        end
      end
      CMPP_CA: begin
        if (ca_clear) begin
          next_s.st    = CMPP_RUN;
          next_s.block = 1'b0;
        end
      end
    endcase
  end

  // ============================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s         <= '0;
      s.st      <= CMPP_RUN;
      s.zcd     <= SENSE_RST[`CMPP_BIT_ZCD];
      s.dsense  <= SENSE_RST[`CMPP_BIT_DSENSE];
      s.qam     <= QUEUE_RST[`CMPP_QAM_HI:`CMPP_QAM_LO];
      s.qem     <= QUEUE_RST[`CMPP_QEM_HI:`CMPP_QEM_LO];
      s.busy    <= `CMPP_BUSY_RST;
      s.r_restr <= 1'b1;
      s.ptype   <= `CMPP_PTYPE_NONE;
      s.selft   <= SELFTEST_SECONDS;
    end else begin
      s <= next_s;
    end
  end

  // ============================================================
  // Attention table
  cmpp_ua_table #(
    .NI (NI),
    .IW (IW)
  ) u_ua (
    .pclk       (pclk),
    .presetn    (presetn),
    .set_vec    (s.ua_set),
    .set_cause  (s.ua_cause),
    .clr_valid  (ua_ack_valid),
    .clr_id     (ua_ack_id),
    .rd_id      (ua_query_id),
    .rd_pending (ua_pending),
    .rd_code    (ua_sense_code)
  );

  // Outputs
  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign rsp_valid             = s.rsp_valid;
  assign rsp_check_pi          = s.rsp_check_pi;
  assign rsp_reject            = s.rsp_reject;
  assign rsp_sense_descriptor  = s.rsp_desc;
  assign rsp_sense_key         = s.rsp_key;
  assign rsp_sense_code        = s.rsp_code;
  assign rsp_tag_preserve      = s.rsp_tag_preserve;
  assign rsp_tag_from_page     = s.rsp_tag_page;
  assign block_tasks           = s.block;
  assign abort_all             = s.abort_all;
  assign abort_initiator_valid = s.abort_one;
  assign abort_initiator_id    = s.abort_id;
  assign reorder_restricted    = s.r_restr;
  assign reorder_free          = s.r_free;
  assign reorder_disabled      = s.r_off;
  assign vpd_blocklen_enable   = s.vpd_en;
  assign ptype_report          = s.ptype;
  assign selftest_seconds      = s.selft;

  // ============================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_check_on;
    cmd_valid && cmd_has_pi && !s.zcd |=> rsp_valid && rsp_check_pi;
  endproperty
  a_check_on: assert property (p_check_on) else $error("protection check not requested");

  property p_check_skip;
    cmd_valid && s.zcd && (cmd_protect_field == 3'h0) |=> rsp_valid && !rsp_check_pi;
  endproperty
  a_check_skip: assert property (p_check_skip) else $error("zero protect field still checked");

  property p_sense_fmt;
    cmd_valid |=> rsp_sense_descriptor == $past(s.dsense);
  endproperty
  a_sense_fmt: assert property (p_sense_fmt) else $error("sense format mismatch");

  property p_reject;
    cmd_valid && cmd_is_write && !cmd_has_pi && s.rjw && medium_pi_formatted
      |=> rsp_reject && (rsp_sense_key == 4'h5) && (rsp_sense_code == 8'h24);
  endproperty
  a_reject: assert property (p_reject) else $error("unprotected write not rejected");

  property p_accept;
    cmd_valid && !s.rjw |=> !rsp_reject;
  endproperty
  a_accept: assert property (p_accept) else $error("write rejected with reject bit clear");

  property p_block;
    (s.st == CMPP_RUN) && err_valid && (s.qem == 2'b00) |=> block_tasks ##1 (block_tasks || $past(ca_clear));
  endproperty
  a_block: assert property (p_block) else $error("tasks not held on allegiance");

  property p_abort_all;
    (s.st == CMPP_RUN) && err_valid && (s.qem == 2'b01)
      |=> abort_all && ((s.ua_set & $past(queued_mask & ~err_onehot)) == $past(queued_mask & ~err_onehot));
  endproperty
  a_abort_all: assert property (p_abort_all) else $error("abort all or attention missing");

  property p_abort_one;
    (s.st == CMPP_RUN) && err_valid && (s.qem == 2'b11)
      |=> abort_initiator_valid && (abort_initiator_id == $past(err_initiator)) && !abort_all;
  endproperty
  a_abort_one: assert property (p_abort_one) else $error("own initiator abort wrong");

  property p_spt;
    ptype_report == (vpd_blocklen_enable ? 3'b110 : 3'b000);
  endproperty
  a_spt: assert property (p_spt) else $error("protection type report wrong");

  property p_block_length_report_bit_ua;
    commit && pwrite && !s.pslverr && (idx == 6'h05) && (blr_new != s.blr) |=> (&s.ua_set);
  endproperty
  a_block_length_report_bit_ua: assert property (p_block_length_report_bit_ua) else $error("no attention on report bit change");

  property p_hdr;
    acc && !pready && pwrite && (idx == 6'h00) && (pwdata[5:0] != 6'h0A) |=> pready && pslverr;
  endproperty
  a_hdr: assert property (p_hdr) else $error("bad header write accepted");

  property p_apb_answer;
    psel && !penable ##1 acc |=> pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer) else $error("APB answer late");

  c_block_clear: cover property (block_tasks ##[1:20] !block_tasks);
  c_reject:      cover property (rsp_valid && rsp_reject);
  c_abort_all:   cover property (abort_all ##[1:4] ua_pending);
  c_apb_err:     cover property (pready && pslverr);
endmodule
`default_nettype wire

// file: shared/cmpp_params.svh
// Constants for the control mode page policy block: offsets, fields, resets, codes
//
// Functional notes
// - Clear zero-check-disable: check all protection info
// - Set: skip checking when protect field zero
// - Sense select 0: fixed format sense data
// - Sense select 1: descriptor format sense data
// - Default reordering keeps per-initiator data integrity
// - Reorder code 0h restricted, 1h free, 8h off, others reserved
// - Queue error 00b: block all tasks during allegiance
// - Queue error 01b: abort all, attention others
// - Queue error 11b: abort that initiator's tasks
// - Ownership set: never alter application tag
// - Ownership clear: tag may change, ignored
// - Tag page enable gates tags from tag page
// - Reject bit clear: accept unprotected writes
// - Reject bit set on protected medium: fail
// - Report bit set: serve page, type 110b
// - Report bit clear: no page, no 110b
// - Report bit change raises unit attention
// - Busy timeout stored, never acted upon
// - Self-test seconds reported as 16 bits
`ifndef CMPP_PARAMS_SVH
`define CMPP_PARAMS_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define CMPP_IDX_CODE     6'h00
`define CMPP_IDX_LEN      6'h01
`define CMPP_IDX_SENSE    6'h02
`define CMPP_IDX_QUEUE    6'h03
`define CMPP_IDX_FIXED    6'h04
`define CMPP_IDX_PROT     6'h05
`define CMPP_IDX_UNUSED   6'h06
`define CMPP_IDX_BUSY     6'h08
`define CMPP_IDX_SELFT    6'h0A

// ============================================================
// Page header and reset values
`define CMPP_PAGE_CODE    8'h0A
`define CMPP_PAGE_LEN     8'h0A
`define CMPP_SENSE_RST    8'h04
`define CMPP_QUEUE_RST    8'h00
`define CMPP_PROT_RST     8'h00
`define CMPP_BUSY_RST     16'h0000

// ============================================================
// Field positions
`define CMPP_BIT_ZCD      3
`define CMPP_BIT_DSENSE   2
`define CMPP_QAM_HI       7
`define CMPP_QAM_LO       4
`define CMPP_QEM_HI       2
`define CMPP_QEM_LO       1
`define CMPP_BIT_OWN      7
`define CMPP_BIT_TPE      5
`define CMPP_BIT_RJW      4
`define CMPP_BIT_BLR      3

// ============================================================
// Field codes
`define CMPP_QAM_RESTRICT 4'h0
`define CMPP_QAM_FREE     4'h1
`define CMPP_QAM_OFF      4'h8
`define CMPP_QEM_BLOCK    2'b00
`define CMPP_QEM_ALL      2'b01
`define CMPP_QEM_RSVD     2'b10
`define CMPP_QEM_OWN      2'b11
`define CMPP_PTYPE_BLKLEN 3'b110
`define CMPP_PTYPE_NONE   3'b000

// ============================================================
// Sense codes
`define CMPP_KEY_NONE     4'h0
`define CMPP_KEY_ILLEGAL  4'h5
`define CMPP_ASC_NONE     8'h00
`define CMPP_ASC_BAD_CDB  8'h24
`define CMPP_ASC_CLEARED  8'h2F
`define CMPP_ASC_CHANGED  8'h2A

`endif

// file: shared/cmpp_pkg.sv
// Types shared by the control mode page policy block
`default_nettype none
package cmpp_pkg;
  // Error handling state, one-hot
  typedef enum logic [1:0] {
    CMPP_RUN = 2'b01,  // Normal task flow
    CMPP_CA  = 2'b10   // Contingent allegiance pending, tasks held
  } cmpp_state_t;
endpackage
`default_nettype wire

// file: hdl/cmpp_ua_table.sv
// Per-initiator unit attention table with registered read port
`include "cmpp_params.svh"
`default_nettype none
module cmpp_ua_table #(
  parameter int NI = 8,
  parameter int IW = 3
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Set side
  input  wire logic [NI-1:0] set_vec,
  input  wire logic          set_cause,
  // Clear side
  input  wire logic          clr_valid,
  input  wire logic [IW-1:0] clr_id,
  // Read side
  input  wire logic [IW-1:0] rd_id,
  output logic               rd_pending,
  output logic [7:0]         rd_code
);
  import cmpp_pkg::*;

  // ============================================================
  // State
  typedef struct packed {
    logic [NI-1:0] pend;       // Attention pending per initiator
    logic [NI-1:0] cause;      // 1: cleared by another, 0: parameters changed
    logic          rd_pending; // Registered read of pend
    logic [7:0]    rd_code;    // Registered additional sense code
  } cmpp_ua_s_t;

  cmpp_ua_s_t    s;
  cmpp_ua_s_t    next_s;
  logic [NI-1:0] next_pend;
  logic [NI-1:0] next_cause;

  // ============================================================
  // Per entry: a new attention wins over a clear in the same cycle
  for (genvar i = 0; i < NI; i++) begin : g_entry
    assign next_pend[i]  = set_vec[i] | (s.pend[i] & ~(clr_valid && (clr_id == IW'(i))));
    assign next_cause[i] = set_vec[i] ? set_cause : s.cause[i];
  end

  // Next state and read port
  always_comb begin
    next_s            = s;
    next_s.pend       = next_pend;
    next_s.cause      = next_cause;
    next_s.rd_pending = s.pend[rd_id];
    next_s.rd_code    = !s.pend[rd_id] ? `CMPP_ASC_NONE :
                        (s.cause[rd_id] ? `CMPP_ASC_CLEARED : `CMPP_ASC_CHANGED);
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign rd_pending = s.rd_pending;
  assign rd_code    = s.rd_code;
endmodule
`default_nettype wire

// file: test/cmpp_initiator_model.sv
// Initiator side model: which initiators hold queued commands
`default_nettype none
module cmpp_initiator_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Queue events
  input  wire logic       enq_valid,
  input  wire logic [2:0] enq_id,
  input  wire logic       abort_all,
  output logic      [7:0] queued_mask
);
  timeunit 1ns;
  timeprecision 1ps;
  // Queue set empties when the target aborts every task
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) queued_mask <= 8'h00;
    else if (abort_all) queued_mask <= 8'h00;
    else if (enq_valid) queued_mask[enq_id] <= 1'b1;
  end
endmodule
`default_nettype wire

// file: test/control_mode_page_policy_bench.sv
// Self-checking bench for the control mode page block
`default_nettype none
module control_mode_page_policy_bench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals
  localparam logic [15:0] SELFT = 16'h0E10; // Arbitrary self-test figure
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_valid, cmd_is_write, cmd_has_pi;
  logic medium_pi_formatted, inquiry_check_flag, rsp_valid, rsp_check_pi, rsp_reject, rsp_sense_descriptor;
  logic rsp_tag_preserve, rsp_tag_from_page, err_valid, ca_clear, block_tasks, abort_all, abort_initiator_valid;
  logic ua_ack_valid, ua_pending, enq_valid, reorder_restricted, reorder_free, reorder_disabled, vpd_blocklen_enable;
  logic [2:0] cmd_protect_field, err_initiator, abort_initiator_id, ua_ack_id, ua_query_id, enq_id, ptype_report;
  logic [3:0] rsp_sense_key;
  logic [7:0] paddr, rsp_sense_code, queued_mask, ua_sense_code, sense_r, prot_r;
  logic [15:0] selftest_seconds;
  logic [31:0] pwdata, prdata;
  logic [33:0] apb_q[$], ea; // Care flag, error, data; ea is the note taken off
  logic [16:0] rsp_q[$];
  int n_errors, samples_checked, cyc;
  cmpp_control_page #(.SELFTEST_SECONDS(SELFT)) u_dut (.*);
  cmpp_initiator_model u_init (.*);
  // Clock at 200 MHz
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========
  // Checking
  task automatic cmp(string what, logic [32:0] e, logic [32:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Results taken off the queues as they appear; ceiling far above the run
  always @(posedge pclk) begin
    cyc++;
    if (pready === 1'b1) begin
      ea = apb_q.pop_front();
      cmp("apb", ea[32:0], {pslverr, ea[33] ? prdata : 32'h0000_0000});
    end
    if (rsp_valid === 1'b1) cmp("rsp", rsp_q.pop_front(),
      {rsp_check_pi, rsp_reject, rsp_sense_descriptor,
      rsp_sense_key, rsp_sense_code, rsp_tag_preserve, rsp_tag_from_page});
    if (cyc == 20000) begin
      n_errors++;
      stop_test();
    end
  end
  // ==========
  // Drivers
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [33:0] e);
    apb_q.push_back(e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d, logic er);
    apb(1'b1, a, d, {1'b0, er, 32'h0000_0000});
  endtask
  task automatic rd(logic [7:0] a, logic [31:0] d, logic er);
    apb(1'b0, a, 32'h0000_0000, {1'b1, er, d});
  endtask
  task automatic cmd(logic w, logic pi, logic [2:0] pf, logic med, logic ick);
    logic ck;
    logic rj;
    ck = pi & ~(sense_r[3] & (pf == 3'h0));
    rj = w & ~pi & prot_r[4] & med;
    rsp_q.push_back({ck, rj, sense_r[2], rj ? {4'h5, 8'h24} : 12'h000, prot_r[7], prot_r[5] & prot_r[7] & ck & ick});
    {cmd_valid, cmd_is_write, cmd_has_pi, cmd_protect_field} <= {1'b1, w, pi, pf};
    {medium_pi_formatted, inquiry_check_flag} <= {med, ick};
    @(posedge pclk) cmd_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic err(logic [2:0] id);
    err_initiator <= id;
    err_valid <= 1'b1;
    @(posedge pclk) err_valid <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic ua(logic [2:0] id, logic [8:0] e);
    ua_query_id <= id;
    repeat (4) @(posedge pclk);
    cmp("attention", e, {ua_pending, ua_sense_code});
  endtask
  // ==========
  // Main sequence
  logic [7:0] qv[5] = '{8'h00, 8'h10, 8'h80, 8'h20, 8'h04};
  logic [2:0] qr[5] = '{3'b100, 3'b010, 3'b001, 3'b001, 3'b001};
  initial begin
    {psel, penable, pwrite, paddr, pwdata, cmd_valid, cmd_is_write, cmd_has_pi, cmd_protect_field} = '0;
    {medium_pi_formatted, inquiry_check_flag, err_valid, err_initiator, ca_clear} = '0;
    {ua_ack_valid, ua_ack_id, ua_query_id, enq_valid, enq_id, presetn} = '0;
    {sense_r, prot_r} = {8'h04, 8'h00};
    void'($urandom(32'h8f7e_2435));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(8'h08, 32'h0000_0004, 1'b0);
    rd(8'h00, 32'h0000_000A, 1'b0);
    wr(8'h00, 32'h0000_000B, 1'b1);
    rd(8'h28, {16'h0000, SELFT}, 1'b0);
    cmp("selftest", SELFT, selftest_seconds);
    wr(8'h10, 32'h0000_00FF, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b0);
    rd(8'h3C, 32'h0000_0000, 1'b1);
    wr(8'h20, 32'h0000_BEEF, 1'b0);
    rd(8'h20, 32'h0000_BEEF, 1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(8'h0C, {24'h00_0000, qv[i]}, i > 2);
      cmp("reorder", qr[i], {reorder_restricted, reorder_free, reorder_disabled});
    end
    wr(8'h0C, 32'h0000_0002, 1'b0);
    {enq_valid, enq_id} <= {1'b1, 3'h1};
    @(posedge pclk) enq_id <= 3'h4;
    @(posedge pclk) enq_valid <= 1'b0;
    err(3'h1);
    cmp("abort all", 1'b1, abort_all);
    ua(3'h4, {1'b1, 8'h2F});
    ua(3'h1, 9'h000);
    {ua_ack_valid, ua_ack_id} <= {1'b1, 3'h4};
    @(posedge pclk) ua_ack_valid <= 1'b0;
    ua(3'h4, 9'h000);
    wr(8'h0C, 32'h0000_0006, 1'b0);
    err(3'h3);
    cmp("abort id", 4'hB, {abort_initiator_valid, abort_initiator_id});
    wr(8'h0C, 32'h0000_0000, 1'b0);
    err(3'h2);
    cmp("block", 1'b1, block_tasks);
    ca_clear <= 1'b1;
    @(posedge pclk) ca_clear <= 1'b0;
    repeat (2) @(posedge pclk);
    cmp("unblock", 1'b0, block_tasks);
    for (int i = 0; i < 6; i++) begin
      sense_r = 8'($urandom_range(3)) << 2;
      prot_r = i == 0 ? 8'h08 : 8'($urandom()) & 8'hB8;
      wr(8'h08, {24'h00_0000, sense_r}, 1'b0);
      wr(8'h14, {24'h00_0000, prot_r}, 1'b0);
      rd(8'h14, {24'h00_0000, prot_r}, 1'b0);
      cmp("blocklen", {prot_r[3] ? 3'b110 : 3'b000, prot_r[3]}, {ptype_report, vpd_blocklen_enable});
      if (i == 0) ua(3'h5, {1'b1, 8'h2A});
      repeat (4) cmd(1'($urandom()), 1'($urandom()), 3'($urandom_range(1)), 1'($urandom()), 1'($urandom()));
    end
    repeat (3) @(posedge pclk);
    stop_test();
  end
endmodule
`default_nettype wire
